// ### design/sasp_pkg.sv
package sasp_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_SEQ = 8'h00;
   localparam logic [7:0] OFF_ESTOP_TRQ = 8'h04;
   localparam logic [7:0] OFF_OVL_LVL = 8'h08;
   localparam logic [7:0] OFF_OVS_LVL = 8'h0C;
   localparam logic [7:0] OFF_RANGE = 8'h10;
   localparam logic [7:0] OFF_MOTOR = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
   localparam logic [7:0] OFF_CTRL = 8'h24;
   localparam logic [7:0] OFF_DEV = 8'h28;
   // reset values
   localparam logic [2:0] RST_SEQ = 3'h0;
   localparam logic [8:0] RST_ESTOP_TRQ = 9'h000;
   localparam logic [8:0] RST_OVL_LVL = 9'h000;
   localparam logic [14:0] RST_OVS_LVL = 15'h0000;
   localparam logic [15:0] RST_RANGE = 16'h000A;
   localparam logic [14:0] RST_MOTOR_MAX = 15'h1770;
   localparam logic [8:0] RST_NORMAL_TRQ = 9'h12C;
   // thresholds
   localparam logic [14:0] STOP_SPEED_RPM = 15'h001E;
   localparam logic [8:0] OVL_MAX_PCT = 9'h073;
   localparam logic [14:0] OVS_MAX = 15'h4E20;
   localparam logic [8:0] TRQ_MAX = 9'h1F4;
   // status bit positions
   localparam int ST_OVS = 0;
   localparam int ST_OVL = 1;
   localparam int ST_SWL = 2;
   localparam int ST_ALM = 3;
   localparam int ST_ALM_CLR = 4;
   localparam int NUM_EV = 5;

   typedef enum logic [1:0] {
      SASP_RUN = 2'b00,
      SASP_DECEL = 2'b01,
      SASP_STOPPED = 2'b10
   } sasp_state_e;

   typedef enum logic [1:0] {
      SASP_BRK_NONE = 2'b00,
      SASP_BRK_DB = 2'b01,
      SASP_BRK_FREE = 2'b10,
      SASP_BRK_ESTOP = 2'b11
   } sasp_brake_e;

   // one control update from the servo loop
   typedef struct packed {
      logic update;
      logic [14:0] speed;
      logic [8:0] load;
      logic signed [31:0] travel;
      logic signed [31:0] cmdMin;
      logic signed [31:0] cmdMax;
      logic [15:0] revTenth;
   } sasp_meas_s;

   // braking choice per sequence value
   function automatic sasp_brake_e sasp_decel_mode(input logic [2:0] seq, input logic needEstop);
      sasp_brake_e m;
      m = SASP_BRK_DB;
      if (seq[2] && needEstop) begin
         m = SASP_BRK_ESTOP;
      end else if (seq[2]) begin
         m = seq[0] ? SASP_BRK_FREE : SASP_BRK_DB;
      end else begin
         m = seq[0] ? SASP_BRK_FREE : SASP_BRK_DB;
      end
      return m;
   endfunction

   function automatic sasp_brake_e sasp_stop_mode(input logic [2:0] seq);
      sasp_brake_e m;
      m = seq[1] ? SASP_BRK_FREE : SASP_BRK_DB;
      return m;
   endfunction
endpackage

// ### design/sasp_limit_calc.sv
`timescale 1ns/1ps
// effective thresholds from the settings; registered outputs
module sasp_limit_calc
   import sasp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // settings
   input wire logic [8:0] ovlSet,
   input wire logic [14:0] ovsSet,
   input wire logic [14:0] motorMax,
   input wire logic [8:0] estopSet,
   input wire logic [8:0] normalTrq,
   // effective values
   output logic [8:0] ovlLimit,
   output logic [15:0] ovsLimit,
   output logic [8:0] estopLimit
);
   logic [8:0] next_ovlLimit;
   logic [15:0] next_ovsLimit;
   logic [8:0] next_estopLimit;
   logic [17:0] scaled;

   // zero selects fallbacks (115 percent, 1.2x motorMax, normalTrq); over-load clamped
   always_comb begin
      scaled = 18'({3'h0, motorMax} * 18'd6) / 18'd5;
      if (ovlSet == 9'h000 || ovlSet > OVL_MAX_PCT) begin
         next_ovlLimit = OVL_MAX_PCT;
      end else begin
         next_ovlLimit = ovlSet;
      end
      if (ovsSet == 15'h0000) begin
         next_ovsLimit = scaled[15:0];
      end else begin
         next_ovsLimit = {1'b0, ovsSet};
      end
      next_estopLimit = (estopSet == 9'h000) ? normalTrq : estopSet;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ovlLimit <= OVL_MAX_PCT;
         ovsLimit <= 16'h0000;
         estopLimit <= 9'h000;
      end else begin
         ovlLimit <= next_ovlLimit;
         ovsLimit <= next_ovsLimit;
         estopLimit <= next_estopLimit;
      end
   end
endmodule

// ### design/sasp_alarm_stop.sv
`timescale 1ns/1ps
// What this block does
// - Values 0..3 choose brake or free-run separately for deceleration and after stop.
// - Values 4..7 emergency-stop while decelerating when the alarm needs it, then brake or coast.
// - Values 4..7 without emergency need decelerate braking on 4 and 6, coasting on 5 and 7.
// - Deviation counts hold during an alarm and are zeroed when it is cancelled.
// - Deceleration ends once speed is at or below 30 r/min.
// - A 0..500 percent torque limit applies during emergency stop.
// - A zero emergency torque setting falls back to the normal torque limit.
// - A zero over-load setting means a 115 percent threshold.
// - The over-load threshold never exceeds 115 percent.
// - Speed above the over-speed setting raises the over-speed fault.
// - A zero over-speed setting means 1.2 times motor maximum speed.
// - Travel beyond the command range by more than the working range raises a fault.
module sasp_alarm_stop
   import sasp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   // control loop side
   input wire sasp_meas_s meas,
   input wire logic extAlarm,
   input wire logic extAlarmEstop,
   input wire logic devIncr,
   input wire logic scaleIncr,
   // drive outputs
   output logic dynamic_brake,
   output logic freeRun,
   output logic estopActive,
   output logic [8:0] torqueLimit,
   output logic alarmActive,
   output logic overspeed_fault,
   output logic software_limit_fault,
   output logic overloadFault,
   output logic [31:0] posDeviation,
   output logic [31:0] scaleDeviation,
   output logic irq
);
   // settings
   logic [2:0] alarm_sequence_setting;
   logic [8:0] estop_torque_setting;
   logic [8:0] overload_level_setting;
   logic [14:0] overspeed_level_setting;
   logic [15:0] working_range_setting;
   logic [14:0] motorMax;
   logic [8:0] normalTrq;
   logic [NUM_EV-1:0] irqStat;
   logic [NUM_EV-1:0] irqMask;
   logic ackDone;
   logic [8:0] ovlLimit;
   logic [15:0] ovsLimit;
   logic [8:0] estopLimit;
   sasp_state_e state;
   sasp_state_e next_state;
   logic latchedEstop;
   logic next_latchedEstop;
   logic clrReq;
   logic [31:0] rdMux;
   logic [31:0] next_rd;
   logic next_ack;
   logic [NUM_EV-1:0] events;
   logic [NUM_EV-1:0] next_irqStat;
   logic ovsNow;
   logic ovlNow;
   logic swlNow;
   logic next_ovs;
   logic next_ovl;
   logic next_swl;
   logic next_alarm;
   logic [31:0] next_posDev;
   logic [31:0] next_scaleDev;
   logic signed [33:0] rangeSteps;
   logic wrHit;
   logic [3:0] wrLanes;

   sasp_limit_calc u_limits (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ovlSet(overload_level_setting),
      .ovsSet(overspeed_level_setting),
      .motorMax(motorMax),
      .estopSet(estop_torque_setting),
      .normalTrq(normalTrq),
      .ovlLimit(ovlLimit),
      .ovsLimit(ovsLimit),
      .estopLimit(estopLimit)
   );

   // one wait cycle per access, answer on second edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ackDone;
   assign wrHit = avs_write & ~ackDone;
   assign wrLanes = avs_byteenable;

   // read decode, unmapped reads zero with decode error
   always_comb begin
      rdMux = 32'h0000_0000;
      case (avs_address)
         OFF_SEQ: rdMux = {29'h0, alarm_sequence_setting};
         OFF_ESTOP_TRQ: rdMux = {23'h0, estop_torque_setting};
         OFF_OVL_LVL: rdMux = {23'h0, overload_level_setting};
         OFF_OVS_LVL: rdMux = {17'h0, overspeed_level_setting};
         OFF_RANGE: rdMux = {16'h0, working_range_setting};
         OFF_MOTOR: rdMux = {8'h0, normalTrq[7:0], 1'b0, motorMax};
         OFF_STATUS: rdMux = {16'h0, estopLimit, 2'h0, state, dynamic_brake, freeRun,
                              estopActive};
         OFF_IRQ_STAT: rdMux = {27'h0, irqStat};
         OFF_IRQ_MASK: rdMux = {27'h0, irqMask};
         OFF_CTRL: rdMux = {31'h0, alarmActive};
         OFF_DEV: rdMux = posDeviation;
         default: rdMux = 32'h0000_0000;
      endcase
      next_rd = (avs_read & ~ackDone) ? rdMux : avs_readdata;
      next_ack = (avs_read | avs_write) & ~ackDone;
   end

   // software clears the alarm by writing ctrl bit 1
   assign clrReq = wrHit && avs_address == OFF_CTRL && wrLanes[0] && avs_writedata[1];

   // bus response and settings registers
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ackDone <= 1'b0;
         avs_readdata <= 32'h0000_0000;
         avs_response <= 2'b00;
         alarm_sequence_setting <= RST_SEQ;
         estop_torque_setting <= RST_ESTOP_TRQ;
         overload_level_setting <= RST_OVL_LVL;
         overspeed_level_setting <= RST_OVS_LVL;
         working_range_setting <= RST_RANGE;
         motorMax <= RST_MOTOR_MAX;
         normalTrq <= RST_NORMAL_TRQ;
         irqMask <= '0;
      end else begin
         ackDone <= next_ack;
         avs_readdata <= next_rd;
         if (next_ack) begin
            avs_response <= (avs_address > OFF_DEV || avs_address[1:0] != 2'b00) ? 2'b11 : 2'b00;
         end
         if (wrHit && wrLanes[0]) begin
            case (avs_address)
               OFF_SEQ: alarm_sequence_setting <= avs_writedata[2:0];
               OFF_ESTOP_TRQ: begin
                  // out-of-range writes saturate; whole word compared so big values never wrap
                  if (avs_writedata > 32'(TRQ_MAX)) begin
                     estop_torque_setting <= TRQ_MAX;
                  end else begin
                     estop_torque_setting <= avs_writedata[8:0];
                  end
               end
               OFF_OVL_LVL: overload_level_setting <= (avs_writedata > 32'(TRQ_MAX)) ?
                                                      TRQ_MAX : avs_writedata[8:0];
               OFF_OVS_LVL: overspeed_level_setting <= (avs_writedata > 32'(OVS_MAX)) ?
                                                       OVS_MAX : avs_writedata[14:0];
               OFF_RANGE: working_range_setting <= avs_writedata[15:0];
               OFF_MOTOR: begin
                  motorMax <= avs_writedata[14:0];
                  normalTrq <= {1'b0, avs_writedata[23:16]};
               end
               OFF_IRQ_MASK: irqMask <= avs_writedata[NUM_EV-1:0];
               default: begin
               end
            endcase
         end
      end
   end

   // fault comparisons each control update
   always_comb begin
      rangeSteps = 34'(signed'({1'b0, working_range_setting})) *
                   34'(signed'({1'b0, meas.revTenth}));
      ovsNow = {1'b0, meas.speed} > ovsLimit;
      ovlNow = meas.load > ovlLimit;
      swlNow = (34'(meas.travel) > 34'(meas.cmdMax) + rangeSteps) ||
               (34'(meas.travel) < 34'(meas.cmdMin) - rangeSteps);
      next_ovs = overspeed_fault;
      next_ovl = overloadFault;
      next_swl = software_limit_fault;
      if (clrReq) begin
         next_ovs = 1'b0;
         next_ovl = 1'b0;
         next_swl = 1'b0;
      end
      if (meas.update) begin
         next_ovs = next_ovs | ovsNow;
         next_ovl = next_ovl | ovlNow;
         next_swl = next_swl | swlNow;
      end
      next_alarm = (alarmActive & ~clrReq) | next_ovs | next_ovl | next_swl | extAlarm;
   end

   // stop sequencer: decel until slow, then after-stop mode
   always_comb begin
      next_state = state;
      next_latchedEstop = latchedEstop;
      case (state)
         SASP_RUN: begin
            if (next_alarm) begin
               next_state = SASP_DECEL;
               next_latchedEstop = extAlarmEstop | next_ovs;
            end
         end
         SASP_DECEL: begin
            if (!alarmActive) begin
               next_state = SASP_RUN;
            end else if (meas.speed <= STOP_SPEED_RPM) begin
               next_state = SASP_STOPPED;
            end
         end
         SASP_STOPPED: begin
            if (!alarmActive) begin
               next_state = SASP_RUN;
            end
         end
         default: next_state = SASP_RUN;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         state <= SASP_RUN;
         latchedEstop <= 1'b0;
      end else begin
         state <= next_state;
         latchedEstop <= next_latchedEstop;
      end
   end

   // brake outputs from the selected mode
   always_comb begin
      sasp_brake_e m;
      m = SASP_BRK_NONE;
      if (state == SASP_DECEL) begin
         m = sasp_decel_mode(alarm_sequence_setting, latchedEstop);
      end else if (state == SASP_STOPPED) begin
         m = sasp_stop_mode(alarm_sequence_setting);
      end
      dynamic_brake = (m == SASP_BRK_DB);
      freeRun = (m == SASP_BRK_FREE);
      estopActive = (m == SASP_BRK_ESTOP);
      torqueLimit = estopActive ? estopLimit : normalTrq;
   end

   // deviation counters freeze in alarm, zero at cancel
   always_comb begin
      next_posDev = posDeviation;
      next_scaleDev = scaleDeviation;
      if (clrReq) begin
         next_posDev = 32'h0000_0000;
         next_scaleDev = 32'h0000_0000;
      end else if (!alarmActive) begin
         next_posDev = posDeviation + {31'h0, devIncr};
         next_scaleDev = scaleDeviation + {31'h0, scaleIncr};
      end
   end

   // sticky events: set wins over write-one-to-clear
   always_comb begin
      events = {clrReq, next_alarm & ~alarmActive, next_swl & ~software_limit_fault,
                next_ovl & ~overloadFault, next_ovs & ~overspeed_fault};
      next_irqStat = irqStat;
      if (wrHit && avs_address == OFF_IRQ_STAT && wrLanes[0]) begin
         next_irqStat = irqStat & ~avs_writedata[NUM_EV-1:0];
      end
      next_irqStat = next_irqStat | events;
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         overspeed_fault <= 1'b0;
         overloadFault <= 1'b0;
         software_limit_fault <= 1'b0;
         alarmActive <= 1'b0;
         posDeviation <= 32'h0000_0000;
         scaleDeviation <= 32'h0000_0000;
         irqStat <= '0;
      end else begin
         overspeed_fault <= next_ovs;
         overloadFault <= next_ovl;
         software_limit_fault <= next_swl;
         alarmActive <= next_alarm;
         posDeviation <= next_posDev;
         scaleDeviation <= next_scaleDev;
         irqStat <= next_irqStat;
      end
   end

   // a set mask bit hides its status bit from the interrupt line
   assign irq = |(irqStat & ~irqMask);
endmodule

// ### sim/sasp_motor_model.sv
`timescale 1ns/1ps
// host controller and motor stand-in; a loop update every fourth cycle
module sasp_motor_model
   import sasp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // operating point asked for by the bench
   input wire logic [14:0] wantSpeed,
   input wire logic [8:0] wantLoad,
   input wire logic signed [31:0] wantTravel,
   // braking from the drive
   input wire logic dynamic_brake,
   input wire logic freeRun,
   input wire logic estopActive,
   // measurement stream
   output sasp_meas_s meas
);
   logic [1:0] phase;
   logic [14:0] speed;
   // any braking mode slows the shaft, so a stop is always reached
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         phase <= 2'h0;
         speed <= 15'h0000;
      end else begin
         phase <= phase + 2'h1;
         if (phase == 2'h3 && (dynamic_brake || freeRun || estopActive)) begin
            speed <= (speed > 15'h01F4) ? speed - 15'h01F4 : 15'h0000;
         end else if (phase == 2'h3) begin
            speed <= wantSpeed;
         end
      end
   end
   // fixed command window 0..100000, 100 counts per tenth revolution
   always_comb begin
      meas.update = (phase == 2'h3);
      meas.speed = speed;
      meas.load = wantLoad;
      meas.travel = wantTravel;
      meas.cmdMin = 32'sh00000000;
      meas.cmdMax = 32'sh000186A0;
      meas.revTenth = 16'h0064;
   end
endmodule

// ### sim/sasp_checker_assertions.sv
`timescale 1ns/1ps
// port-level checks of stop sequencing and fault latching
module sasp_checker
   import sasp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // bus and loop
   input wire logic [7:0] avs_address,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_writedata,
   input wire sasp_meas_s meas,
   // drive outputs
   input wire logic dynamic_brake,
   input wire logic freeRun,
   input wire logic estopActive,
   input wire logic [8:0] torqueLimit,
   input wire logic alarmActive,
   input wire logic overspeed_fault,
   input wire logic software_limit_fault,
   input wire logic overloadFault,
   input wire logic [31:0] posDeviation,
   input wire logic [31:0] scaleDeviation
);
   logic clrHit;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // clear-bit write in its first cycle, where the block acts on it
   assign clrHit = avs_write && avs_waitrequest && avs_address == OFF_CTRL && avs_writedata[1];
   sequence s_clear;
      clrHit;
   endsequence
   // leaving coast or emergency stop while the alarm stands
   sequence s_leave;
      $fell(freeRun || estopActive) ##0 alarmActive;
   endsequence
   property p_latch(f);
      f && !clrHit |=> f;
   endproperty
   a_ovs_latch: assert property (p_latch(overspeed_fault)) else $error("overspeed dropped");
   a_ovl_latch: assert property (p_latch(overloadFault)) else $error("overload dropped");
   a_swl_latch: assert property (p_latch(software_limit_fault)) else $error("limit dropped");
   a_fault_update: assert property ($rose(overspeed_fault || overloadFault ||
      software_limit_fault) |-> $past(meas.update)) else $error("fault off update");
   a_ovs_alarm: assert property ($rose(overspeed_fault) |-> ##[0:1] alarmActive)
      else $error("no alarm on overspeed");
   a_brake_one: assert property ($onehot0({dynamic_brake, freeRun, estopActive}))
      else $error("two brake modes");
   a_idle_brake: assert property (!alarmActive [*3] |-> !(dynamic_brake || freeRun ||
      estopActive)) else $error("braking without alarm");
   a_normal_trq: assert property (!estopActive |-> torqueLimit == RST_NORMAL_TRQ)
      else $error("torque limit off normal");
   a_dev_hold: assert property (alarmActive && $past(alarmActive) |-> $stable(posDeviation)
      && $stable(scaleDeviation)) else $error("deviation moved in alarm");
   a_dev_zero: assert property (s_clear |=> posDeviation == 32'h0 && scaleDeviation == 32'h0)
      else $error("deviation not zeroed");
   a_stop_speed: assert property (s_leave |-> $past(meas.speed) <= STOP_SPEED_RPM)
      else $error("stop phase too early");
endmodule
bind sasp_alarm_stop sasp_checker u_chk (.sys_clk(sys_clk), .rstn(rstn),
   .avs_address(avs_address), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .avs_writedata(avs_writedata), .meas(meas), .dynamic_brake(dynamic_brake),
   .freeRun(freeRun), .estopActive(estopActive), .torqueLimit(torqueLimit),
   .alarmActive(alarmActive), .overspeed_fault(overspeed_fault),
   .software_limit_fault(software_limit_fault), .overloadFault(overloadFault),
   .posDeviation(posDeviation), .scaleDeviation(scaleDeviation));

// ### sim/tb.sv
`timescale 1ns/1ps
// drive bench: register tasks, motor stand-in, expected values from the settings
module tb;
   import sasp_pkg::*;
   logic sys_clk, rstn, avs_read, avs_write, avs_waitrequest, extAlarm, extAlarmEstop;
   logic devIncr, scaleIncr, dynamic_brake, freeRun, estopActive, alarmActive, irq, est;
   logic overspeed_fault, software_limit_fault, overloadFault;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, posDeviation, scaleDeviation, rdData;
   logic [1:0] avs_response, lastResp;
   logic [8:0] torqueLimit, wantLoad;
   logic [14:0] wantSpeed;
   logic signed [31:0] wantTravel;
   sasp_meas_s meas;
   int failures, total_checks;
   sasp_alarm_stop u_dut (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .meas(meas), .extAlarm(extAlarm),
      .extAlarmEstop(extAlarmEstop), .devIncr(devIncr), .scaleIncr(scaleIncr),
      .dynamic_brake(dynamic_brake), .freeRun(freeRun), .estopActive(estopActive),
      .torqueLimit(torqueLimit), .alarmActive(alarmActive), .overspeed_fault(overspeed_fault),
      .software_limit_fault(software_limit_fault), .overloadFault(overloadFault),
      .posDeviation(posDeviation), .scaleDeviation(scaleDeviation), .irq(irq));
   sasp_motor_model u_motor (.sys_clk(sys_clk), .rstn(rstn), .wantSpeed(wantSpeed),
      .wantLoad(wantLoad), .wantTravel(wantTravel), .dynamic_brake(dynamic_brake),
      .freeRun(freeRun), .estopActive(estopActive), .meas(meas));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   // request held until waitrequest is seen low, then released
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
         n++;
         @(posedge sys_clk);
      end
      if (n == 20) failures++;
      rdData = avs_readdata;
      lastResp = avs_response;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic clr();
      @(posedge sys_clk);
      extAlarm <= 1'b0;
      bus(1'b1, OFF_CTRL, 32'h2);
      tick(3);
   endtask
   function automatic logic flt(input int k);
      return k == 0 ? overspeed_fault : k == 1 ? overloadFault : software_limit_fault;
   endfunction
   // set a threshold, present one value, check the fault and its latch against the expected flag
   task automatic tryFault(input int k, input logic [31:0] s, input logic [31:0] v, logic e);
      bus(1'b1, k == 0 ? OFF_OVS_LVL : k == 1 ? OFF_OVL_LVL : OFF_RANGE, s);
      @(posedge sys_clk);
      if (k == 0) wantSpeed <= v[14:0];
      else if (k == 1) wantLoad <= v[8:0];
      else wantTravel <= v;
      tick(16);
      chk("fault", flt(k), e);
      chk("alarm", alarmActive, e);
      wantSpeed <= 15'h0000;
      wantLoad <= 9'h000;
      wantTravel <= 32'sh0000C350;
      tick(16);
      chk("latched", flt(k), e);
      clr();
      chk("cleared", flt(k), 1'b0);
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         devIncr <= 1'b1;
         scaleIncr <= 1'b1;
         @(posedge sys_clk);
         devIncr <= 1'b0;
         scaleIncr <= 1'b0;
      end
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      summarize();
   end
   initial begin
      {rstn, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {extAlarm, extAlarmEstop, devIncr, scaleIncr, wantSpeed, wantLoad} = '0;
      wantTravel = 32'sh0000C350;
      failures = 0;
      total_checks = 0;
      tick(8);
      rstn <= 1'b1;
      chk("trq rst", torqueLimit, 32'h12C);
      bus(1'b0, OFF_RANGE, 32'h0);
      chk("range rst", rdData, 32'hA);
      bus(1'b0, OFF_SEQ, 32'h0);
      chk("seq rst", rdData, 32'h0);
      bus(1'b1, OFF_ESTOP_TRQ, 32'h258);
      bus(1'b0, OFF_ESTOP_TRQ, 32'h0);
      chk("trq sat", rdData, 32'h1F4);
      bus(1'b0, 8'h40, 32'h0);
      chk("unmapped", {rdData[29:0], lastResp}, 32'h3);
      // every sequence value, with and without an emergency-stop alarm
      for (int s = 0; s < 8; s++) begin
         for (int ne = 0; ne < 2; ne++) begin
            bus(1'b1, OFF_SEQ, s);
            bus(1'b1, OFF_ESTOP_TRQ, s == 7 ? 32'h0 : 32'hFA);
            wantSpeed <= 15'h0BB8;
            tick(12);
            extAlarmEstop <= ne[0];
            extAlarm <= 1'b1;
            tick(4);
            est = s > 3 && ne == 1;
            chk("decel db", dynamic_brake, !est && !s[0]);
            chk("decel free", freeRun, !est && s[0]);
            chk("decel estop", estopActive, est);
            if (est) chk("estop trq", torqueLimit, s == 7 ? 32'h12C : 32'hFA);
            tick(40);
            chk("stop db", dynamic_brake, !s[1]);
            chk("stop free", freeRun, s[1]);
            clr();
         end
      end
      wantSpeed <= 15'h0000;
      pulse(5);
      extAlarm <= 1'b1;
      tick(4);
      pulse(3);
      chk("scale dev", scaleDeviation, 32'h5);
      bus(1'b0, OFF_DEV, 32'h0);
      chk("pos dev", rdData, 32'h5);
      clr();
      chk("dev zero", posDeviation | scaleDeviation, 32'h0);
      // sticky status, mask and clear-by-one
      bus(1'b1, OFF_IRQ_STAT, 32'h1F);
      bus(1'b1, OFF_IRQ_MASK, 32'h1F);
      extAlarm <= 1'b1;
      tick(4);
      chk("irq masked", irq, 1'b0);
      bus(1'b0, OFF_IRQ_STAT, 32'h0);
      chk("irq stat", rdData, 32'h8);
      bus(1'b1, OFF_IRQ_MASK, 32'h0);
      tick(1);
      chk("irq on", irq, 1'b1);
      bus(1'b1, OFF_IRQ_STAT, 32'h8);
      tick(1);
      chk("irq w1c", irq, 1'b0);
      clr();
      chk("irq clr ev", irq, 1'b1);
      tryFault(0, 32'h0, 32'h1C20, 1'b0);
      tryFault(0, 32'h0, 32'h1C21, 1'b1);
      tryFault(0, 32'h3E8, 32'h3E9, 1'b1);
      tryFault(1, 32'h0, 32'h73, 1'b0);
      tryFault(1, 32'h0, 32'h74, 1'b1);
      tryFault(1, 32'hC8, 32'h74, 1'b1);
      tryFault(1, 32'h32, 32'h33, 1'b1);
      tryFault(2, 32'hA, 32'h00018A88, 1'b0);
      tryFault(2, 32'hA, 32'h00018A89, 1'b1);
      tryFault(2, 32'h3, 32'hFFFFFED3, 1'b1);
      summarize();
   end
endmodule
